// ---- core/pced_pkg.sv ----
// package: register map, field layout and reset values of the pin change edge detector
// Function
// - first port rising enables, bits 5..0
// - first port falling enables, bits 5..0
// - second port rising enables, bits 7..4
// - second port falling enables, bits 7..4
// - disabled polarity never sets a flag
// - first port flag set on enabled edge
// - second port flag set on enabled edge
// - flags sticky, cleared by software or reset
// - flags software writable, hardware settable too
// - first port bits 7..6 read zero
// - second port bits 3..0 read zero
// - all enables and flags reset zero
// - summary flag is OR of all flags
// - master enable gates only the request
// - edge during flag write leaves flag set
// - enabled edge wakes while master enable is set, flags updated first
package pced_pkg;
	localparam logic [11:0] OFS_FIRST_RISE = 12'h000;
	localparam logic [11:0] OFS_FIRST_FALL = 12'h004;
	localparam logic [11:0] OFS_FIRST_FLAGS = 12'h008;
	localparam logic [11:0] OFS_SECOND_RISE = 12'h00C;
	localparam logic [11:0] OFS_SECOND_FALL = 12'h010;
	localparam logic [11:0] OFS_SECOND_FLAGS = 12'h014;
	localparam logic [11:0] OFS_IRQ_CONTROL = 12'h018;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h01C;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h020;
	// implemented bits of each port's registers
	localparam logic [7:0] FIRST_MASK = 8'h3F;
	localparam logic [7:0] SECOND_MASK = 8'hF0;
	localparam logic [7:0] REG_RESET = 8'h00;
	// irq control: bit 0 summary flag (read only), bit 1 master enable
	localparam int CTRL_SUMMARY_BIT = 0;
	localparam int CTRL_MASTER_BIT = 1;
	// irq status: bit 0 first port change, bit 1 second port change
	localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage

// ---- core/pced_sync_if.sv ----
// interface: synchronised rising and falling edge strobes of both ports between the edge unit and the top
`timescale 1ns/1ps
interface pced_sync_if;
	logic [7:0] first_rise;
	logic [7:0] first_fall;
	logic [7:0] second_rise;
	logic [7:0] second_fall;
	modport source (output first_rise, output first_fall, output second_rise, output second_fall);
	modport sink (input first_rise, input first_fall, input second_rise, input second_fall);
endinterface

// ---- core/pced_edge.sv ----
// edge unit: three-stage pin synchronisers and per-pin edge strobes
`timescale 1ns/1ps
module pced_edge (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] first_port_pin,
	input wire logic [7:0] second_port_pin,
	pced_sync_if.source edges
);
	logic [7:0] a1, a2, a3;
	logic [7:0] b1, b2, b3;
	logic [7:0] a_prev, b_prev;
	// a change counts once stages two and three agree; a_prev holds the last agreed level
	wire [7:0] a_agree = ~(a2 ^ a3);
	wire [7:0] b_agree = ~(b2 ^ b3);
	wire [7:0] a_level = (a_agree & a3) | (~a_agree & a_prev);
	wire [7:0] b_level = (b_agree & b3) | (~b_agree & b_prev);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			a1 <= 8'h00;
			a2 <= 8'h00;
			a3 <= 8'h00;
			a_prev <= 8'h00;
			b1 <= 8'h00;
			b2 <= 8'h00;
			b3 <= 8'h00;
			b_prev <= 8'h00;
		end else begin
			a1 <= first_port_pin;
			a2 <= a1;
			a3 <= a2;
			a_prev <= a_level;
			b1 <= second_port_pin;
			b2 <= b1;
			b3 <= b2;
			b_prev <= b_level;
		end
	end

	assign edges.first_rise = a_level & ~a_prev & pced_pkg::FIRST_MASK;
	assign edges.first_fall = ~a_level & a_prev & pced_pkg::FIRST_MASK;
	assign edges.second_rise = b_level & ~b_prev & pced_pkg::SECOND_MASK;
	assign edges.second_fall = ~b_level & b_prev & pced_pkg::SECOND_MASK;
endmodule

// ---- core/pced_apb.sv ----
// apb slave front end: zero-wait decode of write and read strobes
`timescale 1ns/1ps
module pced_apb (
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	output logic pready,
	output logic wr_stb,
	output logic rd_stb,
	output logic [11:0] word_addr,
	output logic mapped
);
	assign pready = 1'b1;
	assign wr_stb = psel & penable & pwrite;
	assign rd_stb = psel & penable & ~pwrite;
	assign word_addr = {paddr[11:2], 2'b00};
	assign mapped = (word_addr <= pced_pkg::OFS_IRQ_MASK);
endmodule

// ---- core/pced_top.sv ----
// top: registers, flags, summary, interrupt and wake logic of the pin change edge detector
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module pced_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] first_port_pin,
	input wire logic [7:0] second_port_pin,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic change_irq,
	output logic wake_req,
	output logic irq
);
	// ----------------------------------------
	// bus front end and edge unit
	// ----------------------------------------
	pced_sync_if edges ();
	logic wr_stb, rd_stb, mapped;
	logic [11:0] word_addr;

	pced_apb u_apb (
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.word_addr(word_addr),
		.mapped(mapped)
	);

	pced_edge u_edge (
		.clock(clock),
		.rst_n(rst_n),
		.first_port_pin(first_port_pin),
		.second_port_pin(second_port_pin),
		.edges(edges.source)
	);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] first_port_rise_enable, first_port_fall_enable, first_port_change_flags;
	logic [7:0] second_port_rise_enable, second_port_fall_enable, second_port_change_flags;
	logic change_irq_master_enable;
	logic [1:0] irq_status, irq_mask;

	function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] ofs, input logic s);
		wr_hit = s & (a == ofs);
	endfunction

	wire [7:0] wbyte = pwdata[7:0];
	wire w_ar = wr_hit(word_addr, pced_pkg::OFS_FIRST_RISE, wr_stb);
	wire w_af = wr_hit(word_addr, pced_pkg::OFS_FIRST_FALL, wr_stb);
	wire w_ag = wr_hit(word_addr, pced_pkg::OFS_FIRST_FLAGS, wr_stb);
	wire w_br = wr_hit(word_addr, pced_pkg::OFS_SECOND_RISE, wr_stb);
	wire w_bf = wr_hit(word_addr, pced_pkg::OFS_SECOND_FALL, wr_stb);
	wire w_bg = wr_hit(word_addr, pced_pkg::OFS_SECOND_FLAGS, wr_stb);
	wire w_ctl = wr_hit(word_addr, pced_pkg::OFS_IRQ_CONTROL, wr_stb);
	wire w_msk = wr_hit(word_addr, pced_pkg::OFS_IRQ_MASK, wr_stb);
	wire r_sts = wr_hit(word_addr, pced_pkg::OFS_IRQ_STATUS, rd_stb);

	// each polarity only counts where its enable is one
	wire [7:0] a_hit = (edges.first_rise & first_port_rise_enable) | (edges.first_fall & first_port_fall_enable);
	wire [7:0] b_hit = (edges.second_rise & second_port_rise_enable) | (edges.second_fall & second_port_fall_enable);

	// a hardware set beats whatever software writes in the same cycle
	wire [7:0] next_a_flags = ((w_ag ? wbyte : first_port_change_flags) | a_hit) & pced_pkg::FIRST_MASK;
	wire [7:0] next_b_flags = ((w_bg ? wbyte : second_port_change_flags) | b_hit) & pced_pkg::SECOND_MASK;

	wire change_summary_flag = (|first_port_change_flags) | (|second_port_change_flags);
	wire [1:0] ev = {|b_hit, |a_hit};
	wire [1:0] next_status = (r_sts ? 2'h0 : irq_status) | ev;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			first_port_rise_enable <= pced_pkg::REG_RESET;
			first_port_fall_enable <= pced_pkg::REG_RESET;
			first_port_change_flags <= pced_pkg::REG_RESET;
			second_port_rise_enable <= pced_pkg::REG_RESET;
			second_port_fall_enable <= pced_pkg::REG_RESET;
			second_port_change_flags <= pced_pkg::REG_RESET;
			change_irq_master_enable <= 1'b0;
			irq_status <= pced_pkg::IRQ_RESET;
			irq_mask <= pced_pkg::IRQ_RESET;
		end else begin
			if (w_ar) first_port_rise_enable <= wbyte & pced_pkg::FIRST_MASK;
			if (w_af) first_port_fall_enable <= wbyte & pced_pkg::FIRST_MASK;
			if (w_br) second_port_rise_enable <= wbyte & pced_pkg::SECOND_MASK;
			if (w_bf) second_port_fall_enable <= wbyte & pced_pkg::SECOND_MASK;
			if (w_ctl) change_irq_master_enable <= pwdata[pced_pkg::CTRL_MASTER_BIT];
			if (w_msk) irq_mask <= pwdata[1:0];
			first_port_change_flags <= next_a_flags;
			second_port_change_flags <= next_b_flags;
			irq_status <= next_status;
		end
	end

	// ----------------------------------------
	// request, wake and read back
	// ----------------------------------------
	// flags keep updating with the master enable off; only the request is gated
	assign change_irq = change_summary_flag & change_irq_master_enable;
	// wake follows the request combinationally; flags are already set in the cycle wake_req rises
	assign wake_req = change_irq;
	assign irq = |(irq_status & irq_mask);

	wire [7:0] ctl_rd = {6'h00, change_irq_master_enable, change_summary_flag};
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		unique case (word_addr)
			pced_pkg::OFS_FIRST_RISE: rd_mux = first_port_rise_enable;
			pced_pkg::OFS_FIRST_FALL: rd_mux = first_port_fall_enable;
			pced_pkg::OFS_FIRST_FLAGS: rd_mux = first_port_change_flags;
			pced_pkg::OFS_SECOND_RISE: rd_mux = second_port_rise_enable;
			pced_pkg::OFS_SECOND_FALL: rd_mux = second_port_fall_enable;
			pced_pkg::OFS_SECOND_FLAGS: rd_mux = second_port_change_flags;
			pced_pkg::OFS_IRQ_CONTROL: rd_mux = ctl_rd;
			pced_pkg::OFS_IRQ_STATUS: rd_mux = {6'h00, irq_status};
			pced_pkg::OFS_IRQ_MASK: rd_mux = {6'h00, irq_mask};
			default: rd_mux = 8'h00;
		endcase
	end
	assign prdata = {24'h000000, rd_mux};
	assign pslverr = psel & penable & ~mapped;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence first_edge_s;
		|a_hit;
	endsequence

	flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		first_edge_s |=> ((first_port_change_flags & $past(a_hit)) == $past(a_hit)))
		else $error("first port flag not set after enabled edge");
	second_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		|b_hit |=> ((second_port_change_flags & $past(b_hit)) == $past(b_hit)))
		else $error("second port flag not set after enabled edge");
	flag_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
		!w_ag |=> ((first_port_change_flags & $past(first_port_change_flags)) == $past(first_port_change_flags)))
		else $error("first port flag dropped without a write");
	first_unimpl_a: assert property (@(posedge clock) disable iff (!rst_n)
		(first_port_change_flags[7:6] == 2'b00) && (first_port_rise_enable[7:6] == 2'b00))
		else $error("first port unimplemented bits set");
	second_unimpl_a: assert property (@(posedge clock) disable iff (!rst_n)
		(second_port_change_flags[3:0] == 4'h0) && (second_port_fall_enable[3:0] == 4'h0))
		else $error("second port unimplemented bits set");
	write_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		(w_ag && |a_hit) |=> ((first_port_change_flags & $past(a_hit)) == $past(a_hit)))
		else $error("edge lost during flag write");
	summary_or_a: assert property (@(posedge clock) disable iff (!rst_n)
		change_summary_flag == ((first_port_change_flags != 8'h00) || (second_port_change_flags != 8'h00)))
		else $error("summary flag mismatch");
	master_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		(!change_irq_master_enable and first_edge_s) |=> (!change_irq && change_summary_flag))
		else $error("master enable gated detection or failed to gate request");
	disabled_pol_a: assert property (@(posedge clock) disable iff (!rst_n)
		(first_port_rise_enable == 8'h00 && first_port_fall_enable == 8'h00 && !w_ag)
		|=> first_port_change_flags == $past(first_port_change_flags))
		else $error("flag set with enables off");
	wake_a: assert property (@(posedge clock) disable iff (!rst_n)
		(change_irq_master_enable and first_edge_s) |=> wake_req)
		else $error("no wake after enabled edge");
endmodule

// ---- verif/pced_pins.sv ----
// partner model: the external pins that feed both ports
`timescale 1ns/1ps
module pced_pins (
	input wire logic clock,
	output logic [7:0] first_port_pin,
	output logic [7:0] second_port_pin
);
	initial begin
		first_port_pin = 8'h00;
		second_port_pin = 8'h00;
	end
	// levels move just after an edge and then hold, so the synchroniser never sees a runt pulse
	task automatic drive(input logic [7:0] a, input logic [7:0] b);
		@(posedge clock);
		first_port_pin <= a;
		second_port_pin <= b;
	endtask
endmodule

// ---- verif/pced_tb.sv ----
// self-checking testbench of the pin change edge detector
`timescale 1ns/1ps
module pced_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, change_irq, wake_req, irq;
	logic [7:0] fpin, spin;
	logic [31:0] seed = 32'h00010431;
	int err_total = 0;
	int n_checks = 0;
	int rm[9] = '{default: 0};
	int fp = 0;
	int sp = 0;
	int wsel[6] = '{0, 1, 3, 4, 6, 8};

	always #20 clock = ~clock;

	pced_top pced_top_i (.clock(clock), .rst_n(rst_n), .first_port_pin(fpin), .second_port_pin(spin),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .change_irq(change_irq), .wake_req(wake_req), .irq(irq));
	pced_pins pced_pins_i (.clock(clock), .first_port_pin(fpin), .second_port_pin(spin));

	// ----
	// helpers
	// ----
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	endfunction
	function automatic int msk(input int k);
		return k < 3 ? 8'h3F : k < 6 ? 8'hF0 : k == 6 ? 8'h02 : k == 8 ? 8'h03 : 8'h00;
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
		n_checks++;
		if (seen !== ex) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, ex);
		end
	endtask
	task automatic apb(input logic wr, input int k, input logic [31:0] d, output logic [31:0] q, output logic e);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= 12'(k * 4);
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (i == 16) begin
			err_total++;
			final_report();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input int k, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, k, d, q, e);
		if (k < 9)
			rm[k] = d & msk(k);
	endtask
	task automatic rdc(input int k, input int ex);
		logic [31:0] q;
		logic e;
		apb(1'b0, k, 32'h00000000, q, e);
		chk(q, ex);
		// a status read clears what it returned
		if (k == 7)
			rm[7] = 0;
	endtask
	task automatic pin_step(input logic [7:0] a, input logic [7:0] b);
		int ea, eb;
		ea = ((a & ~fp & rm[0]) | (~a & fp & rm[1])) & 8'h3F;
		eb = ((b & ~sp & rm[3]) | (~b & sp & rm[4])) & 8'hF0;
		rm[2] |= ea;
		rm[5] |= eb;
		rm[7] |= (eb != 0 ? 2 : 0) | (ea != 0 ? 1 : 0);
		fp = a;
		sp = b;
		pced_pins_i.drive(a, b);
		// flag lands four edges after the pin moves
		repeat (6) @(posedge clock);
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		logic [31:0] q;
		logic e;
		int k, smy;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		for (k = 0; k < 9; k++)
			rdc(k, 0);
		for (k = 0; k < 6; k++) begin
			wr(k, 32'hFFFFFFFF);
			rdc(k, msk(k));
		end
		wr(2, 0);
		wr(5, 0);
		rdc(2, 0);
		apb(1'b0, 9, 32'h00000000, q, e);
		chk(e, 1);
		chk(q, 0);
		for (k = 0; k < 60; k++) begin
			seed = nxt(seed);
			wr(wsel[seed % 6], seed[15:8]);
			pin_step(seed[23:16], seed[31:24]);
			smy = (rm[2] | rm[5]) != 0;
			rdc(2, rm[2]);
			rdc(5, rm[5]);
			rdc(6, (rm[6] & 2) | smy);
			chk(change_irq, rm[6][1] & smy);
			chk(wake_req, rm[6][1] & smy);
			chk(irq, (rm[7] & rm[8]) != 0);
			if (k % 3 == 0) begin
				rdc(7, rm[7]);
				wr(2 + 3 * (k % 2), seed[7:0]);
				rdc(2 + 3 * (k % 2), rm[2 + 3 * (k % 2)]);
			end
		end
		// an edge that meets a flag clear in the same cycle must leave its flag set
		pin_step(fp[7:0] & 8'hFE, sp[7:0]);
		wr(0, 32'h00000001);
		fp = fp | 1;
		rm[7] |= 1;
		pced_pins_i.drive(fp[7:0], sp[7:0]);
		// strobe reaches the flag four edges after the pin moves, the access edge of this write
		@(posedge clock);
		wr(2, 32'h00000000);
		rm[2] = 1;
		rdc(2, rm[2]);
		rdc(7, rm[7]);
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		for (k = 0; k < 9; k++)
			rdc(k, 0);
		chk(change_irq, 0);
		final_report();
	end
endmodule
